// file: rtl/nmps_mode_if.sv
// Interface: mode fields to the decoder and decoded port controls back
`default_nettype none
interface nmps_mode_if;
    logic [1:0] port_sel;       // net_port_select field
    logic media_auto;           // automatic port choice
    logic tp_link_ok;           // twisted pair link seen
    logic thr_bit;              // threshold_or_idle_bit
    logic codec_lb;             // codec_loopback_select
    logic int_lb;               // internal_loopback
    logic loop_en;              // loopback enable
    nmps_pkg::nmps_port_type port;  // port in use
    logic low_thr;              // reduced squelch in force
    logic idle_high;            // AUI rests high
    nmps_pkg::nmps_lb_type lb_mode; // loopback mode

    modport dec
    (
        input port_sel, media_auto, tp_link_ok, thr_bit, codec_lb,
        input int_lb, loop_en,
        output port, low_thr, idle_high, lb_mode
    );
    modport top
    (
        output port_sel, media_auto, tp_link_ok, thr_bit, codec_lb,
        output int_lb, loop_en,
        input port, low_thr, idle_high, lb_mode
    );
endinterface
`default_nettype wire

// file: rtl/nmps_pkg.sv
// Package: offsets, field layout, reset values and codes of the port select slice
`default_nettype none
package nmps_pkg;
    // ------------------------------------------------------------
    // Register byte addresses on the APB
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h00;   // network_mode_control
    localparam logic [7:0] ADDR_CTRL = 8'h04;   // stop, suspend, media select
    localparam logic [7:0] ADDR_STAT = 8'h08;   // decoded port state
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int MODE_W = 16;

    // ------------------------------------------------------------
    // Field positions in network_mode_control
    // ------------------------------------------------------------
    localparam int BIT_CODEC_LB = 10;   // codec_loopback_select
    localparam int BIT_THR_IDLE = 9;    // threshold_or_idle_bit
    localparam int BIT_PSEL_HI = 8;     // net_port_select[1]
    localparam int BIT_PSEL_LO = 7;     // net_port_select[0]
    localparam int BIT_INT_LB = 6;      // internal_loopback
    localparam int BIT_LOOP_EN = 2;     // loopback enable

    // Field positions in the control register
    localparam int BIT_STOP = 0;
    localparam int BIT_SUSPEND = 1;
    localparam int BIT_MEDIA_AUTO = 2;

    // Field positions in the status register
    localparam int BIT_ST_PORT_LO = 0;  // active port code, 2 bits
    localparam int BIT_ST_LB_LO = 2;    // loopback mode, 2 bits
    localparam int BIT_ST_LOW_THR = 4;
    localparam int BIT_ST_IDLE_HI = 5;
    localparam int BIT_ST_LINK = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_RESET = 16'h0000;
    localparam logic STOP_RESET = 1'b1;     // stopped, so setup is open
    localparam logic SUSPEND_RESET = 1'b0;
    localparam logic MEDIA_AUTO_RESET = 1'b0;

    // ------------------------------------------------------------
    // Port codes and loopback modes
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        NMPS_PORT_AUI = 2'b00,
        NMPS_PORT_TP = 2'b01,
        NMPS_PORT_SERIAL = 2'b10,
        NMPS_PORT_RSVD = 2'b11
    } nmps_port_type;

    typedef enum logic [1:0]
    {
        NMPS_LB_NORMAL = 2'b00,
        NMPS_LB_EXTERNAL = 2'b01,
        NMPS_LB_INT_CODEC = 2'b10,
        NMPS_LB_INT_BYPASS = 2'b11
    } nmps_lb_type;
endpackage
`default_nettype wire

// file: rtl/nmps_port_decode.sv
// Decoder: port choice, bit 9 meaning and loopback mode
`default_nettype none
module nmps_port_decode
(
    nmps_mode_if.dec m
);
    // ------------------------------------------------------------
    // Port choice
    // ------------------------------------------------------------
    // Auto mode follows link state; manual mode takes the field
    always_comb
    begin
        if (m.media_auto)
        begin
            // Field has no effect here
            m.port = m.tp_link_ok ? nmps_pkg::NMPS_PORT_TP
                                  : nmps_pkg::NMPS_PORT_AUI;
        end
        else
        begin
            // Straight field decode, 11 kept as reserved
            m.port = nmps_pkg::nmps_port_type'(m.port_sel);
        end
    end

    // ------------------------------------------------------------
    // Bit 9: threshold on TP, idle level on AUI
    // ------------------------------------------------------------
    always_comb
    begin
        // Meaning depends on the port in use
        m.low_thr = m.thr_bit && (m.port == nmps_pkg::NMPS_PORT_TP);
        // Idle level only under software selection
        m.idle_high = m.thr_bit && !m.media_auto
                      && (m.port == nmps_pkg::NMPS_PORT_AUI);
    end

    // ------------------------------------------------------------
    // Loopback mode
    // ------------------------------------------------------------
    always_comb
    begin
        if (!m.loop_en)
        begin
            m.lb_mode = nmps_pkg::NMPS_LB_NORMAL;
        end
        else if (!m.int_lb)
        begin
            m.lb_mode = nmps_pkg::NMPS_LB_EXTERNAL;
        end
        else
        begin
            // Bit 10 picks codec in or out of the loop
            m.lb_mode = m.codec_lb ? nmps_pkg::NMPS_LB_INT_BYPASS
                                   : nmps_pkg::NMPS_LB_INT_CODEC;
        end
    end
endmodule
`default_nettype wire

// file: rtl/nmps_top.sv
// Top: APB slave holding the mode slice and driving the port controls
`default_nettype none
module nmps_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nmps_pkg::ADDR_W-1:0] paddr,
    input wire logic [nmps_pkg::DATA_W-1:0] pwdata,
    input wire logic tp_link_ok,
    output logic pready,
    output logic [nmps_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    output logic port_aui_en,
    output logic port_tp_en,
    output logic port_serial_en,
    output logic rx_low_threshold,
    output logic aui_idle_high,
    output logic [1:0] loopback_mode
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [nmps_pkg::MODE_W-1:0] mode_reg;  // network_mode_control
    logic [nmps_pkg::MODE_W-1:0] next_mode_reg;
    logic stop;                 // controller stopped
    logic next_stop;
    logic suspend;              // controller suspended
    logic next_suspend;
    logic media_auto;           // bus config media select
    logic next_media_auto;
    logic next_pready;
    logic [nmps_pkg::DATA_W-1:0] next_prdata;
    logic next_pslverr;
    logic next_aui, next_tp, next_serial;
    logic next_low_thr, next_idle_high;
    logic [1:0] next_lb;
    logic setup;                // first cycle of a transfer
    logic wr_done;              // write completes at this edge
    logic unlocked;             // mode slice open to software
    logic [nmps_pkg::DATA_W-1:0] rd_word;
    nmps_mode_if m ();

    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    assign m.port_sel = mode_reg[nmps_pkg::BIT_PSEL_HI:nmps_pkg::BIT_PSEL_LO];
    assign m.media_auto = media_auto;
    assign m.tp_link_ok = tp_link_ok;
    assign m.thr_bit = mode_reg[nmps_pkg::BIT_THR_IDLE];
    assign m.codec_lb = mode_reg[nmps_pkg::BIT_CODEC_LB];
    assign m.int_lb = mode_reg[nmps_pkg::BIT_INT_LB];
    assign m.loop_en = mode_reg[nmps_pkg::BIT_LOOP_EN];

    nmps_port_decode u_decode
    (
        .m(m)
    );

    // ------------------------------------------------------------
    // APB decode and register next state
    // ------------------------------------------------------------
    // Answer comes in the first access cycle; no wait states needed
    always_comb
    begin
        setup = psel && !penable;
        wr_done = psel && penable && pready && pwrite;
        unlocked = stop || suspend;
        next_mode_reg = mode_reg;
        next_stop = stop;
        next_suspend = suspend;
        next_media_auto = media_auto;
        if (wr_done && paddr == nmps_pkg::ADDR_MODE && unlocked)
        begin
            // Writes while running are dropped silently
            next_mode_reg = '0;
            next_mode_reg[nmps_pkg::BIT_CODEC_LB] =
                pwdata[nmps_pkg::BIT_CODEC_LB];
            next_mode_reg[nmps_pkg::BIT_THR_IDLE] =
                pwdata[nmps_pkg::BIT_THR_IDLE];
            next_mode_reg[nmps_pkg::BIT_PSEL_HI] =
                pwdata[nmps_pkg::BIT_PSEL_HI];
            next_mode_reg[nmps_pkg::BIT_PSEL_LO] =
                pwdata[nmps_pkg::BIT_PSEL_LO];
            next_mode_reg[nmps_pkg::BIT_INT_LB] = pwdata[nmps_pkg::BIT_INT_LB];
            next_mode_reg[nmps_pkg::BIT_LOOP_EN] =
                pwdata[nmps_pkg::BIT_LOOP_EN];
        end
        if (wr_done && paddr == nmps_pkg::ADDR_CTRL)
        begin
            // Control is always writable, else the lock could never open
            next_stop = pwdata[nmps_pkg::BIT_STOP];
            next_suspend = pwdata[nmps_pkg::BIT_SUSPEND];
            next_media_auto = pwdata[nmps_pkg::BIT_MEDIA_AUTO];
        end
    end

    // ------------------------------------------------------------
    // Read mux and response
    // ------------------------------------------------------------
    always_comb
    begin
        rd_word = '0;
        next_pslverr = 1'b0;
        unique case (paddr)
            nmps_pkg::ADDR_MODE:
            begin
                // Locked slice reads as zero
                if (unlocked)
                begin
                    rd_word[nmps_pkg::MODE_W-1:0] = mode_reg;
                end
            end
            nmps_pkg::ADDR_CTRL:
            begin
                rd_word[nmps_pkg::BIT_STOP] = stop;
                rd_word[nmps_pkg::BIT_SUSPEND] = suspend;
                rd_word[nmps_pkg::BIT_MEDIA_AUTO] = media_auto;
            end
            nmps_pkg::ADDR_STAT:
            begin
                rd_word[nmps_pkg::BIT_ST_PORT_LO +: 2] = m.port;
                rd_word[nmps_pkg::BIT_ST_LB_LO +: 2] = m.lb_mode;
                rd_word[nmps_pkg::BIT_ST_LOW_THR] = m.low_thr;
                rd_word[nmps_pkg::BIT_ST_IDLE_HI] = m.idle_high;
                rd_word[nmps_pkg::BIT_ST_LINK] = tp_link_ok;
            end
            default:
            begin
                // Unmapped address: error, data zero
                next_pslverr = setup;
            end
        endcase
        next_pready = setup;
        next_prdata = (setup && !pwrite) ? rd_word : '0;
    end

    // ------------------------------------------------------------
    // Port control next state
    // ------------------------------------------------------------
    // Reserved code 11 enables no port at all
    always_comb
    begin
        next_aui = (m.port == nmps_pkg::NMPS_PORT_AUI);
        next_tp = (m.port == nmps_pkg::NMPS_PORT_TP);
        next_serial = (m.port == nmps_pkg::NMPS_PORT_SERIAL);
        next_low_thr = m.low_thr;
        next_idle_high = m.idle_high;
        next_lb = m.lb_mode;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset lands on AUI with bit 9 clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg <= nmps_pkg::MODE_RESET;
            stop <= nmps_pkg::STOP_RESET;
            suspend <= nmps_pkg::SUSPEND_RESET;
            media_auto <= nmps_pkg::MEDIA_AUTO_RESET;
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
            port_aui_en <= 1'b1;
            port_tp_en <= 1'b0;
            port_serial_en <= 1'b0;
            rx_low_threshold <= 1'b0;
            aui_idle_high <= 1'b0;
            loopback_mode <= nmps_pkg::NMPS_LB_NORMAL;
        end
        else
        begin
            mode_reg <= next_mode_reg;
            stop <= next_stop;
            suspend <= next_suspend;
            media_auto <= next_media_auto;
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            port_aui_en <= next_aui;
            port_tp_en <= next_tp;
            port_serial_en <= next_serial;
            rx_low_threshold <= next_low_thr;
            aui_idle_high <= next_idle_high;
            loopback_mode <= next_lb;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic seen_clock;           // high from the first edge after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen_clock <= 1'b0;
        end
        else
        begin
            seen_clock <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_reset_port_field: assert property (
        !seen_clock |-> (mode_reg == nmps_pkg::MODE_RESET) && port_aui_en)
        else $error("mode slice not clear after reset");
    chk_port_aui_decode: assert property (
        !media_auto && m.port_sel == 2'b00 |=> port_aui_en && !port_tp_en)
        else $error("field 00 did not select AUI");
    chk_port_rsvd_decode: assert property (
        !media_auto && m.port_sel == 2'b11
        |=> !port_aui_en && !port_tp_en && !port_serial_en)
        else $error("reserved port code enabled a port");
    chk_auto_select_tp: assert property (
        media_auto && tp_link_ok |=> port_tp_en && !port_serial_en)
        else $error("auto select ignored link");
    chk_locked_write: assert property (
        wr_done && paddr == nmps_pkg::ADDR_MODE && !stop && !suspend
        |=> $stable(mode_reg))
        else $error("mode slice written while running");
    chk_locked_read: assert property (
        setup && !pwrite && paddr == nmps_pkg::ADDR_MODE && !unlocked
        |=> prdata == '0 && pready)
        else $error("mode slice read while running");
    chk_low_thr_gate: assert property (
        rx_low_threshold |-> port_tp_en && $past(m.thr_bit))
        else $error("low threshold outside twisted pair");
    chk_idle_level_gate: assert property (
        aui_idle_high |-> port_aui_en && !$past(media_auto))
        else $error("idle level outside manual AUI");
    chk_bit9_meaning: assert property (
        !rx_low_threshold || !aui_idle_high)
        else $error("bit 9 acting on two ports");
    chk_loop_bypass: assert property (
        m.loop_en && m.int_lb && m.codec_lb
        |=> loopback_mode == nmps_pkg::NMPS_LB_INT_BYPASS)
        else $error("codec bypass loopback not decoded");
    chk_loop_external: assert property (
        m.loop_en && !m.int_lb |=> loopback_mode == nmps_pkg::NMPS_LB_EXTERNAL)
        else $error("external loopback not decoded");
endmodule
`default_nettype wire

// file: sim/nmps_medium_model.sv
// Twisted pair medium model: link pulses seen by the port
`default_nettype none
module nmps_medium_model
#(
    parameter int LINK_DELAY = 4  // Pulse cycles before link is good
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cable_in,
    output logic tp_link_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt; // Cycles of pulses seen so far, held once it reaches LINK_DELAY
    // Link good only after steady pulses; a pulled cable drops it at once
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 0;
            tp_link_ok <= 1'b0;
        end
        else if (!cable_in)
        begin
            cnt <= 0;
            tp_link_ok <= 1'b0;
        end
        else
        begin
            if (cnt < LINK_DELAY)
                cnt <= cnt + 1;
            tp_link_ok <= (cnt >= LINK_DELAY);
        end
    end
endmodule
`default_nettype wire

// file: sim/test_network_port_mode_select.sv
// Testbench: port select, bit 9 and loopback slice over APB
`default_nettype none
module test_network_port_mode_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic cable_in = 1'b0; // Medium model cable state
    logic tp_link_ok;
    logic pready, pslverr, port_aui_en, port_tp_en, port_serial_en;
    logic rx_low_threshold, aui_idle_high;
    logic [1:0] loopback_mode;
    logic [31:0] prdata, rd; // Last read word
    logic er; // Last error flag
    logic [4:0] ports_seen; // aui, tp, serial, low thr, idle high
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    assign ports_seen = {port_aui_en, port_tp_en, port_serial_en,
                         rx_low_threshold, aui_idle_high};
    // 50 MHz clock
    always #10 pclk = ~pclk;
    nmps_top u_nmps_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .tp_link_ok(tp_link_ok), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .port_aui_en(port_aui_en),
        .port_tp_en(port_tp_en), .port_serial_en(port_serial_en),
        .rx_low_threshold(rx_low_threshold),
        .aui_idle_high(aui_idle_high), .loopback_mode(loopback_mode));
    nmps_medium_model u_nmps_medium_model (.pclk(pclk),
        .presetn(presetn), .cable_in(cable_in), .tp_link_ok(tp_link_ok));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // One APB transfer; returns at the completion edge, bus released
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        // A missing answer is a mismatch, not a silent pass
        if (pready !== 1'b1)
        begin
            chk(pready, 1'b1, "no pready");
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Port outputs follow the register one edge late
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        apb(1'b0, nmps_pkg::ADDR_MODE, 32'h0);
        chk(rd, 32'h0, "mode reset");
        apb(1'b0, nmps_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h1, "ctrl reset");
        chk(ports_seen, 5'h10, "ports reset");
        $display("reset test done");
    endtask
    // Every port code with bit 9 low and high
    task automatic t_ports;
        logic [1:0] c;
        logic b, lo, hi;
        for (int i = 0; i < 8; i++)
        begin
            c = i[1:0];
            b = i[2];
            lo = b & (c == 2'b01);
            hi = b & (c == 2'b00);
            apb(1'b1, nmps_pkg::ADDR_MODE, {22'h0, b, c, 7'h00});
            settle;
            chk(ports_seen, {c == 2'b00, c == 2'b01, c == 2'b10, lo, hi},
                "port decode");
            apb(1'b0, nmps_pkg::ADDR_STAT, 32'h0);
            chk(rd, {26'h0, hi, lo, 2'b00, c}, "status");
        end
        $display("port test done");
    endtask
    // All loop enable, internal and codec bit combinations
    task automatic t_loop;
        logic [1:0] e;
        for (int i = 0; i < 8; i++)
        begin
            e = !i[0] ? 2'b00 : !i[1] ? 2'b01 : i[2] ? 2'b11 : 2'b10;
            apb(1'b1, nmps_pkg::ADDR_MODE, {21'h0, i[2], 3'h0, i[1],
                3'h0, i[0], 2'h0});
            settle;
            chk(loopback_mode, e, "loop mode");
        end
        $display("loopback test done");
    endtask
    // Automatic port choice ignores the field and the idle bit
    task automatic t_auto;
        int n;
        n = 0;
        apb(1'b1, nmps_pkg::ADDR_CTRL, 32'h5);
        apb(1'b1, nmps_pkg::ADDR_MODE, 32'h0300);
        settle;
        chk({ports_seen[4:2], aui_idle_high}, 4'h8, "auto aui");
        @(posedge pclk);
        cable_in <= 1'b1;
        while (tp_link_ok !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        settle;
        chk(ports_seen[4:2], 3'h2, "auto tp");
        apb(1'b0, nmps_pkg::ADDR_STAT, 32'h0);
        chk(rd, 32'h51, "auto status");
        @(posedge pclk);
        cable_in <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        chk(ports_seen[4:2], 3'h4, "link lost");
        apb(1'b1, nmps_pkg::ADDR_CTRL, 32'h1);
        $display("auto test done");
    endtask
    // Running controller refuses mode access; suspend reopens it
    task automatic t_lock;
        apb(1'b1, nmps_pkg::ADDR_MODE, 32'h0080);
        apb(1'b1, nmps_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, nmps_pkg::ADDR_MODE, 32'h0300);
        settle;
        chk(ports_seen, 5'h08, "locked write");
        apb(1'b0, nmps_pkg::ADDR_MODE, 32'h0);
        chk(rd, 32'h0, "locked read");
        apb(1'b1, nmps_pkg::ADDR_CTRL, 32'h2);
        apb(1'b0, nmps_pkg::ADDR_MODE, 32'h0);
        chk(rd, 32'h0080, "suspend read");
        apb(1'b1, nmps_pkg::ADDR_MODE, 32'h0100);
        settle;
        chk(ports_seen, 5'h04, "suspend write");
        apb(1'b1, 8'h10, 32'h0);
        chk(er, 1'b1, "unmapped write");
        apb(1'b0, 8'h0C, 32'h0);
        chk(er, 1'b1, "unmapped read error");
        chk(rd, 32'h0, "unmapped read data");
        apb(1'b1, nmps_pkg::ADDR_CTRL, 32'h1);
        $display("lock test done");
    endtask
    // Hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            error_cnt++;
            $display("BAD %0t bench timeout", $time);
            conclude();
        end
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_ports();
        t_loop();
        t_auto();
        t_lock();
        conclude();
    end
endmodule
`default_nettype wire
